// *** design/fsr_cycle.sv ***
// One read or one write cycle on the flash parallel pins
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_cycle (
	input  wire logic  clk_sys,
	input  wire logic  reset,
	fsr_cyc_if.eng     cyc,
	output logic [21:0] flash_addr,
	output logic        flash_ce_n,
	output logic        flash_oe_n,
	output logic        flash_we_n,
	input  wire logic [15:0] flash_dq_in,
	output logic [15:0] flash_dq_out,
	output logic        flash_dq_oe
);
	localparam logic [3:0] RD_CYC = 4'(`FSR_RD_CYC);
	localparam logic [3:0] WE_CYC = 4'(`FSR_WE_CYC);

	logic        busy_q, busy_d;
	logic        wr_q, wr_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [21:0] addr_q, addr_d;
	logic [15:0] wdat_q, wdat_d;
	logic [15:0] rdat_q, rdat_d;
	logic        done_q, done_d;

	// Next cycle state: strobe held for the access time, then released
	always_comb begin
		busy_d = busy_q;
		wr_d   = wr_q;
		cnt_d  = cnt_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		done_d = 1'b0;
		if (!busy_q && cyc.start) begin
			busy_d = 1'b1;
			wr_d   = cyc.write;
			addr_d = cyc.addr;
			wdat_d = cyc.wdata;
			cnt_d  = cyc.write ? WE_CYC : RD_CYC;
		end else if (busy_q) begin
			if (cnt_q == 4'h1) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				if (!wr_q)
					rdat_d = flash_dq_in; // Sampled at end of the full access
			end else begin
				cnt_d = cnt_q - 4'h1;
			end
		end
	end

	// Cycle registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy_q <= 1'b0;
			wr_q   <= 1'b0;
			cnt_q  <= 4'h0;
			addr_q <= `FSR_ADDR_RST;
			wdat_q <= `FSR_DATA_RST;
			rdat_q <= `FSR_DATA_RST;
			done_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			wr_q   <= wr_d;
			cnt_q  <= cnt_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			done_q <= done_d;
		end
	end

	// Pin drive; data enable is low while driving
	assign flash_addr   = addr_q;
	assign flash_ce_n   = !busy_q;
	assign flash_oe_n   = !(busy_q && !wr_q);
	assign flash_we_n   = !(busy_q && wr_q);
	assign flash_dq_out = wdat_q;
	assign flash_dq_oe  = !(busy_q && wr_q);
	assign cyc.done     = done_q;
	assign cyc.rdata    = rdat_q;
endmodule : fsr_cycle
`default_nettype wire

// *** design/fsr_poller.sv ***
// Host-side controller that polls flash write status through its pins
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_poller #(
	parameter int ERASE_GAP_CYC = `FSR_ERASE_GAP_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [3:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [31:0]      sw_rdata,
	output logic [21:0]      flash_addr,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	output logic             flash_we_n,
	input  wire logic [15:0] flash_dq_in,
	output logic [15:0]      flash_dq_out,
	output logic             flash_dq_oe,
	input  wire logic        ready_busy_n
);
	fsr_cyc_if cyc ();

	fsr_pkg::fsr_state_t  st_q, st_d;
	fsr_pkg::fsr_result_t res_q, res_d;
	logic [21:0] addr_q, addr_d;
	logic [15:0] data_q, data_d;
	logic [15:0] first_q, first_d;
	logic [15:0] last_q, last_d;
	logic        start_q, start_d;
	logic        write_q, write_d;
	logic [15:0] wdat_q, wdat_d;
	logic        to_seen_q, to_seen_d;
	logic        win_pre_q, win_pre_d;
	logic        win_rej_q, win_rej_d;
	logic        gap_ok_q, gap_ok_d;
	logic [15:0] gap_q, gap_d;
	logic [1:0]  rby_q, rby_d;
	logic [31:0] rdata_q, rdata_d;

	// Erase gap in clocks, cut to the counter width
	localparam logic [15:0] GAP = 16'(ERASE_GAP_CYC);

	// True when toggle bit one differs between two reads
	function automatic logic toggled(input logic [15:0] a, input logic [15:0] b);
		return a[`FSR_BIT_TOG1] != b[`FSR_BIT_TOG1];
	endfunction : toggled

	// True when a strobe addresses the given register index
	function automatic logic reg_hit(input logic stb, input logic [3:0] idx,
		input logic [3:0] sel);
		return stb && (idx == sel);
	endfunction : reg_hit

	// Control register decode
	logic go_poll, go_wr, go_rd, go_abort, sel_ctrl;
	assign sel_ctrl = reg_hit(sw_wr, sw_addr, `FSR_REG_CTRL);
	assign go_poll  = sel_ctrl && sw_wdata[`FSR_CTRL_POLL];
	assign go_wr    = sel_ctrl && sw_wdata[`FSR_CTRL_WRITE];
	assign go_rd    = sel_ctrl && sw_wdata[`FSR_CTRL_READ];
	assign go_abort = sel_ctrl && sw_wdata[`FSR_CTRL_ABORT];

	// Sequencer busy whenever a poll or a single cycle is under way
	logic seq_busy;
	assign seq_busy = (st_q != fsr_pkg::FSR_IDLE);

	// Polling sequencer and software registers
	always_comb begin
		st_d      = st_q;
		res_d     = res_q;
		addr_d    = addr_q;
		data_d    = data_q;
		first_d   = first_q;
		last_d    = last_q;
		start_d   = 1'b0;
		write_d   = write_q;
		wdat_d    = wdat_q;
		to_seen_d = to_seen_q;
		win_pre_d = win_pre_q;
		win_rej_d = win_rej_q;
		gap_ok_d  = gap_ok_q;
		gap_d     = (gap_q != 16'h0000) ? gap_q - 16'h0001 : gap_q;
		if (reg_hit(sw_wr, sw_addr, `FSR_REG_ADDR))
			addr_d = sw_wdata[21:0];
		if (reg_hit(sw_wr, sw_addr, `FSR_REG_DATA))
			data_d = sw_wdata[15:0];
		// Status read clears the reject flag; a set in the same cycle wins below
		if (reg_hit(sw_rd, sw_addr, `FSR_REG_STATUS))
			win_rej_d = 1'b0;
		unique case (st_q)
			// Poll, write and read commands are taken only while idle
			fsr_pkg::FSR_IDLE: begin
				if (go_poll) begin
					st_d      = fsr_pkg::FSR_RD_A;
					res_d     = fsr_pkg::FSR_RES_NONE;
					to_seen_d = 1'b0;
					start_d   = 1'b1;
					write_d   = 1'b0;
				end else if (go_wr) begin
					st_d    = fsr_pkg::FSR_WR_ONE;
					start_d = 1'b1;
					write_d = 1'b1;
					wdat_d  = data_q;
				end else if (go_rd) begin
					st_d    = fsr_pkg::FSR_RD_ONE;
					start_d = 1'b1;
					write_d = 1'b0;
				end
			end
			fsr_pkg::FSR_RD_A: begin
				if (cyc.done) begin
					first_d = cyc.rdata;
					last_d  = cyc.rdata;
					st_d    = fsr_pkg::FSR_RD_B;
					start_d = 1'b1;
				end
			end
			fsr_pkg::FSR_RD_B: begin
				if (cyc.done) begin
					last_d = cyc.rdata;
					st_d   = fsr_pkg::FSR_CHECK;
				end
			end
			// Abort is honoured only between pairs, so a flash cycle is never cut
			fsr_pkg::FSR_CHECK: begin
				if (!toggled(first_q, last_q)) begin
					res_d = fsr_pkg::FSR_RES_DONE;
					st_d  = fsr_pkg::FSR_IDLE;
				end else if (last_q[`FSR_BIT_TIMEOUT]) begin
					to_seen_d = 1'b1;
					st_d      = fsr_pkg::FSR_RD_C;
					start_d   = 1'b1;
				end else if (go_abort) begin
					st_d = fsr_pkg::FSR_IDLE;
				end else begin
					st_d    = fsr_pkg::FSR_RD_A;
					start_d = 1'b1;
				end
			end
			fsr_pkg::FSR_RD_C: begin
				if (cyc.done) begin
					first_d = cyc.rdata;
					st_d    = fsr_pkg::FSR_RD_D;
					start_d = 1'b1;
				end
			end
			fsr_pkg::FSR_RD_D: begin
				if (cyc.done) begin
					last_d = cyc.rdata;
					st_d   = fsr_pkg::FSR_JUDGE;
				end
			end
			// Toggle may stop just as the timeout rises, hence the second pair
			fsr_pkg::FSR_JUDGE: begin
				if (!toggled(first_q, last_q)) begin
					res_d = fsr_pkg::FSR_RES_DONE;
					st_d  = fsr_pkg::FSR_IDLE;
				end else begin
					res_d   = fsr_pkg::FSR_RES_FAIL;
					st_d    = fsr_pkg::FSR_RESET;
					start_d = 1'b1;
					write_d = 1'b1;
					wdat_d  = `FSR_RESET_CMD;
				end
			end
			// Reset command cycle, then back to idle
			fsr_pkg::FSR_RESET: begin
				if (cyc.done)
					st_d = fsr_pkg::FSR_IDLE;
			end
			// Single write restarts the erase gap counter
			fsr_pkg::FSR_WR_ONE: begin
				if (cyc.done) begin
					st_d     = fsr_pkg::FSR_IDLE;
					gap_d    = GAP;
					gap_ok_d = (gap_q != 16'h0000);
				end
			end
			// Single read, also tracking the erase window flag
			fsr_pkg::FSR_RD_ONE: begin
				if (cyc.done) begin
					last_d = cyc.rdata;
					st_d   = fsr_pkg::FSR_IDLE;
					// Window flag before and after a sector erase write
					if (cyc.rdata[`FSR_BIT_WINDOW] && !win_pre_q)
						win_rej_d = 1'b1;
					win_pre_d = cyc.rdata[`FSR_BIT_WINDOW];
				end
			end
			default: st_d = fsr_pkg::FSR_IDLE;
		endcase
	end

	// Software read mux; data appears the cycle after the strobe
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (sw_rd) begin
			unique case (sw_addr)
				`FSR_REG_ADDR:   rdata_d = {10'h000, addr_q};
				`FSR_REG_DATA:   rdata_d = {16'h0000, data_q};
				`FSR_REG_STATUS: rdata_d = {25'h0000000, gap_ok_q, win_rej_q,
					to_seen_q, rby_q[1],
					res_q, seq_busy};
				`FSR_REG_LAST:   rdata_d = {16'h0000, last_q};
				default:         rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q      <= fsr_pkg::FSR_IDLE;
			res_q     <= fsr_pkg::FSR_RES_NONE;
			addr_q    <= `FSR_ADDR_RST;
			data_q    <= `FSR_DATA_RST;
			first_q   <= `FSR_DATA_RST;
			last_q    <= `FSR_DATA_RST;
			start_q   <= 1'b0;
			write_q   <= 1'b0;
			wdat_q    <= `FSR_DATA_RST;
			to_seen_q <= 1'b0;
			win_pre_q <= 1'b0;
			win_rej_q <= 1'b0;
			gap_ok_q  <= 1'b0;
			gap_q     <= 16'h0000;
			rdata_q   <= 32'h0000_0000;
		end else begin
			st_q      <= st_d;
			res_q     <= res_d;
			addr_q    <= addr_d;
			data_q    <= data_d;
			first_q   <= first_d;
			last_q    <= last_d;
			start_q   <= start_d;
			write_q   <= write_d;
			wdat_q    <= wdat_d;
			to_seen_q <= to_seen_d;
			win_pre_q <= win_pre_d;
			win_rej_q <= win_rej_d;
			gap_ok_q  <= gap_ok_d;
			gap_q     <= gap_d;
			rdata_q   <= rdata_d;
		end
	end

	// Ready/busy synchroniser next value; only the second stage feeds status
	always_comb begin
		rby_d = {rby_q[0], ready_busy_n};
	end

	// Ready/busy synchroniser stages, released high like the idle pin
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			rby_q <= 2'b11;
		else
			rby_q <= rby_d;
	end

	// Software read data and cycle engine requests
	assign sw_rdata  = rdata_q;
	assign cyc.start = start_q;
	assign cyc.write = write_q;
	assign cyc.addr  = addr_q;
	assign cyc.wdata = wdat_q;

	// Bus cycle engine driving the flash pins
	fsr_cycle u_cycle (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.cyc          (cyc.eng),
		.flash_addr   (flash_addr),
		.flash_ce_n   (flash_ce_n),
		.flash_oe_n   (flash_oe_n),
		.flash_we_n   (flash_we_n),
		.flash_dq_in  (flash_dq_in),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe)
	);
endmodule : fsr_poller
`default_nettype wire

// *** inc/fsr_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the flash status poller
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// Clock rate and link timing
`define FSR_CLK_MHZ         20
`define FSR_CYC_NS          50
`define FSR_RD_CYC_NS       120
`define FSR_RD_CYC          ((`FSR_RD_CYC_NS + `FSR_CYC_NS - 1) / `FSR_CYC_NS)
`define FSR_WE_CYC_NS       100
`define FSR_WE_CYC          ((`FSR_WE_CYC_NS + `FSR_CYC_NS - 1) / `FSR_CYC_NS)
`define FSR_ERASE_GAP_US    50
`define FSR_ERASE_GAP_CYC   ((`FSR_ERASE_GAP_US * `FSR_CLK_MHZ))

// Data bit positions of status
`define FSR_BIT_POLL        7
`define FSR_BIT_TOG1        6
`define FSR_BIT_TIMEOUT     5
`define FSR_BIT_WINDOW      3
`define FSR_BIT_TOG2        2

// Register offsets of the software port
`define FSR_REG_CTRL        4'h0
`define FSR_REG_ADDR        4'h1
`define FSR_REG_DATA        4'h2
`define FSR_REG_STATUS      4'h3
`define FSR_REG_LAST        4'h4

// Control fields
`define FSR_CTRL_POLL       0
`define FSR_CTRL_WRITE      1
`define FSR_CTRL_READ       2
`define FSR_CTRL_ABORT      3

// Reset values
`define FSR_ADDR_RST        22'h000000
`define FSR_DATA_RST        16'h0000
`define FSR_RESET_CMD       16'h00f0

`endif

// *** inc/fsr_cyc_if.sv ***
// Handshake between the poller and its bus cycle engine
`timescale 1ns/100ps
`default_nettype none
interface fsr_cyc_if;
	logic        start;
	logic        write;
	logic [21:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;

	modport ctl (output start, output write, output addr, output wdata,
		input done, input rdata);
	modport eng (input start, input write, input addr, input wdata,
		output done, output rdata);
endinterface : fsr_cyc_if
`default_nettype wire

// *** inc/fsr_pkg.sv ***
// Types of the flash status poller
package fsr_pkg;
	typedef enum logic [3:0] {
		FSR_IDLE    = 4'b0000,
		FSR_RD_A    = 4'b0001,
		FSR_RD_B    = 4'b0010,
		FSR_CHECK   = 4'b0011,
		FSR_RD_C    = 4'b0100,
		FSR_RD_D    = 4'b0101,
		FSR_JUDGE   = 4'b0110,
		FSR_RESET   = 4'b0111,
		FSR_WR_ONE  = 4'b1000,
		FSR_RD_ONE  = 4'b1001
	} fsr_state_t;

	typedef enum logic [1:0] {
		FSR_RES_NONE = 2'b00,
		FSR_RES_DONE = 2'b01,
		FSR_RES_FAIL = 2'b10
	} fsr_result_t;
endpackage : fsr_pkg

// *** verif/fsr_flash_model.sv ***
// Behavioural flash device answering status reads and command writes
`timescale 1ns/100ps
`default_nettype none
module fsr_flash_model (
	input  wire logic [21:0] flash_addr,
	input  wire logic        flash_oe_n,
	input  wire logic        flash_we_n,
	input  wire logic [15:0] dq,
	input  wire logic [7:0]  n_reads,
	input  wire logic        hang,
	output logic [15:0]      dev_dq,
	output logic             ready_busy_n
);
	logic        busy = 1'b0;
	logic        tog1 = 1'b0;
	logic        tog2 = 1'b0;
	logic        tout = 1'b0;
	logic [7:0]  left = 8'h00;
	logic [7:0]  cnt  = 8'h00;
	logic [15:0] mem  = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [15:0] wd   = 16'h00f0;
	logic [15:0] word;
	// Flags on their data bits while busy, array data once finished
	assign word = busy ? {8'h00, ~mem[7], tog1, tout, 1'b0, (cnt > 8'h01), tog2, 2'b00}
		: mem;
	// A released bus shows the inverse of the last word, not an all-ones pulled-up value
	assign dev_dq = flash_oe_n ? ~last : word;
	assign ready_busy_n = ~busy;
	// Each finished read advances the algorithm
	always @(posedge flash_oe_n) begin
		last = word;
		if (busy) begin
			tog1 = ~tog1;
			if (flash_addr[21:15] == 7'h00) tog2 = ~tog2;
			cnt = cnt + 8'h01;
			if (left != 8'h00) left = left - 8'h01;
			else if (hang) tout = 1'b1;
			else busy = 1'b0;
		end
	end
	// Data taken inside the strobe, command acted on at its rising edge
	always @(negedge flash_we_n) #10 wd = dq;
	always @(posedge flash_we_n) begin
		if (wd == 16'h00f0) begin
			busy = 1'b0;
			tout = 1'b0;
		end else if (busy && cnt <= 8'h01) begin
			left = left + 8'h01;
		end else if (!busy) begin
			mem = wd;
			busy = 1'b1;
			left = n_reads;
			cnt = 8'h00;
		end
	end
endmodule : fsr_flash_model
`default_nettype wire

// *** verif/fsr_poller_monitor.sv ***
// Checker of the poller's flash pin cycles
`timescale 1ns/100ps
`default_nettype none
module fsr_poller_monitor #(
	parameter int ERASE_GAP_CYC = 1000
) (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [21:0] flash_addr,
	input wire logic        flash_ce_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic [15:0] flash_dq_out,
	input wire logic        flash_dq_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Strobe shapes of one read and one write
	sequence s_rd;
		!flash_oe_n [*3] ##1 flash_oe_n;
	endsequence
	sequence s_wr;
		!flash_we_n [*2] ##1 flash_we_n;
	endsequence
	AST_RD_LEN: assert property ($fell(flash_oe_n) |-> s_rd) else $error("read length");
	AST_WR_LEN: assert property ($fell(flash_we_n) |-> s_wr) else $error("write length");
	AST_GAP: assert property ($rose(flash_oe_n) |-> flash_ce_n) else $error("no gap");
	AST_CE: assert property (!flash_oe_n || !flash_we_n |-> !flash_ce_n) else $error("ce");
	AST_EXCL: assert property (flash_oe_n || flash_we_n) else $error("oe and we");
	AST_DRV: assert property (!flash_we_n |-> !flash_dq_oe) else $error("dq undriven");
	AST_RLS: assert property (!flash_oe_n |-> flash_dq_oe) else $error("dq clash");
	AST_HOLD: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
		else $error("addr moved");
endmodule : fsr_poller_monitor
bind fsr_poller fsr_poller_monitor #(.ERASE_GAP_CYC(ERASE_GAP_CYC)) u_mon (.clk_sys, .reset,
	.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the flash status poller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clk_sys  = 1'b0;
	logic        reset    = 1'b1;
	logic [3:0]  sw_addr  = 4'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic        sw_wr    = 1'b0;
	logic        sw_rd    = 1'b0;
	logic        hang     = 1'b0;
	logic [7:0]  n_reads  = 8'h03;
	logic [31:0] sw_rdata, st;
	logic [21:0] flash_addr;
	logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, ready_busy_n;
	logic [15:0] flash_dq_out, dev_dq, dq_w;
	int          failures = 0;
	int          checks   = 0;
	// Shared data lines
	assign dq_w = flash_dq_oe ? dev_dq : flash_dq_out;
	always #25 clk_sys = ~clk_sys;
	fsr_poller #(.ERASE_GAP_CYC(20)) u_dut (.clk_sys, .reset, .sw_addr, .sw_wdata, .sw_wr,
		.sw_rd, .sw_rdata, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
		.flash_dq_in(dq_w), .flash_dq_out, .flash_dq_oe, .ready_busy_n);
	fsr_flash_model u_flash (.flash_addr, .flash_oe_n, .flash_we_n, .dq(dq_w), .n_reads,
		.hang, .dev_dq, .ready_busy_n);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk_sys);
		sw_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk_sys);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : rd
	task automatic idle;
		st = 32'h1;
		for (int i = 0; i < 1000 && st[0] !== 1'b0; i++) rd(4'h3, st);
		chk(st & 32'h1, 32'h0);
	endtask : idle
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	// Watchdog well beyond the longest poll
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		report_and_stop;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		// Idle status, registers and an unmapped index
		rd(4'h3, st);
		chk(st & 32'h1f, 32'h08);
		wr(4'h1, 32'hffffffff);
		rd(4'h1, st);
		chk(st, 32'h003fffff);
		rd(4'hf, st);
		chk(st, 32'h0);
		// Program, poll to completion, then array data
		wr(4'h1, 32'h8000);
		wr(4'h2, 32'h12);
		wr(4'h0, 32'h2);
		idle;
		wr(4'h0, 32'h1);
		idle;
		rd(4'h3, st);
		chk(st & 32'h1f, 32'h0a);
		wr(4'h0, 32'h4);
		idle;
		rd(4'h4, st);
		chk(st, 32'h12);
		// Program that never ends: timeout, fail, reset command
		hang <= 1'b1;
		wr(4'h2, 32'h55);
		wr(4'h0, 32'h2);
		idle;
		wr(4'h0, 32'h1);
		idle;
		rd(4'h3, st);
		chk(st & 32'h1f, 32'h1c);
		// Long operation: window rises between single reads
		hang <= 1'b0;
		n_reads <= 8'hc8;
		wr(4'h1, 32'h0);
		wr(4'h0, 32'h2);
		idle;
		chk(st & 32'h9, 32'h0);
		// Second write well inside the erase gap
		wr(4'h0, 32'h2);
		idle;
		rd(4'h3, st);
		chk(st & 32'h40, 32'h40);
		repeat (3) begin
			wr(4'h0, 32'h4);
			repeat (8) @(posedge clk_sys);
		end
		rd(4'h3, st);
		chk(st & 32'h20, 32'h20);
		rd(4'h3, st);
		chk(st & 32'h20, 32'h0);
		rd(4'h4, st);
		chk(st & 32'h88, 32'h88);
		// Abandoned poll, then a fresh poll from the start
		wr(4'h0, 32'h1);
		st = 32'h1;
		for (int i = 0; i < 100 && st[0] !== 1'b0; i++) begin
			wr(4'h0, 32'h8);
			rd(4'h3, st);
		end
		chk(st & 32'h1, 32'h0);
		wr(4'h0, 32'h1);
		idle;
		rd(4'h3, st);
		chk(st & 32'h7, 32'h2);
		report_and_stop;
	end
endmodule : testbench
`default_nettype wire
